// ==== include/iow_pkg.sv ====
package iow_pkg;

  localparam logic [15:0] WD_PORT = 16'h0443;
  localparam logic [15:0] INDEX_PORT = 16'h03F0;
  localparam logic [15:0] DATA_PORT = 16'h03F1;
  localparam logic [7:0] UNLOCK_CODE = 8'h87;
  localparam logic [7:0] SELECT_CODE = 8'h14;
  localparam logic [7:0] ENABLE_CODE = 8'h9C;
  localparam logic [7:0] DISABLE_CODE = 8'h8C;

  localparam longint TIMEOUT_NS = 64'h000000005F5E1000;
  localparam longint CLK_NS = 64'h0000000000000064;
  // The division truncates, so the watchdog never waits longer than the nominal interval.
  localparam int TIMEOUT_CYC = int'(TIMEOUT_NS / CLK_NS);
  localparam int CNT_W = 24;
  localparam int RST_CYC = 8;
  localparam int RST_W = 4;
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
  localparam logic [RST_W-1:0] RST_LEN = RST_CYC[RST_W-1:0];

  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00,
    UNL_ONE = 2'b01,
    UNL_TWO = 2'b11,
    UNL_SEL = 2'b10
  } iow_unlock_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } iow_io_t;

  typedef struct packed {
    iow_unlock_t unlock;
    logic enabled;
    logic armed;
    logic [CNT_W-1:0] cnt;
    logic [RST_W-1:0] rst_left;
    logic cpu_reset;
    logic irq;
    logic [1:0] mode_sync;
  } iow_state_t;

endpackage : iow_pkg

// ==== src/iow_watchdog.sv ====
`timescale 1ns/1ps
module iow_watchdog #(
  parameter int TIMEOUT_CYC = iow_pkg::TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire iow_pkg::iow_io_t io,
  input wire logic irq_mode,
  output logic cpu_reset,
  output logic irq,
  output logic enabled,
  output logic armed
);

  localparam int LAST_INT = TIMEOUT_CYC - 1;
  localparam logic [iow_pkg::CNT_W-1:0] LAST = LAST_INT[iow_pkg::CNT_W-1:0];

  iow_pkg::iow_state_t s_q;
  iow_pkg::iow_state_t s_d;
  logic wd_wr;
  logic wd_rd;
  logic idx_wr;
  logic dat_wr;
  logic expire;
  logic irq_sel;

  assign wd_wr = io.wr && io.addr == iow_pkg::WD_PORT;
  assign wd_rd = io.rd && io.addr == iow_pkg::WD_PORT;
  assign idx_wr = io.wr && io.addr == iow_pkg::INDEX_PORT;
  assign dat_wr = io.wr && io.addr == iow_pkg::DATA_PORT;
  // mode after two flops
  // The mode comes from a board strap, so only the second flop is read.
  assign irq_sel = s_q.mode_sync[1];
  // A read in the expiry cycle wins, so a late but valid refresh is honoured.
  // timeout expiry
  assign expire = s_q.armed && s_q.enabled && s_q.cnt == LAST && !wd_rd;

  always_comb
  begin
    s_d = s_q;
    s_d.mode_sync = {s_q.mode_sync[0], irq_mode};
    // count in clocks
    // The step comes first so that disable, arm, refresh and expiry override it.
    if (s_q.armed && s_q.enabled)
    begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    if (idx_wr)
    begin
      case (s_q.unlock)
        iow_pkg::UNL_IDLE:
          s_d.unlock = io.data == iow_pkg::UNLOCK_CODE ? iow_pkg::UNL_ONE : iow_pkg::UNL_IDLE;
        iow_pkg::UNL_ONE:
          s_d.unlock = io.data == iow_pkg::UNLOCK_CODE ? iow_pkg::UNL_TWO : iow_pkg::UNL_IDLE;
        iow_pkg::UNL_TWO:
          s_d.unlock = io.data == iow_pkg::SELECT_CODE ? iow_pkg::UNL_SEL : iow_pkg::UNL_IDLE;
        default:
          s_d.unlock = iow_pkg::UNL_IDLE;
      endcase
    end
    else if (dat_wr)
    begin
      s_d.unlock = iow_pkg::UNL_IDLE;
      if (s_q.unlock == iow_pkg::UNL_SEL && io.data == iow_pkg::ENABLE_CODE)
      begin
        s_d.enabled = 1'b1;
      end
      if (s_q.unlock == iow_pkg::UNL_SEL && io.data == iow_pkg::DISABLE_CODE)
      begin
        s_d.enabled = 1'b0;
        s_d.armed = 1'b0;
        s_d.cnt = iow_pkg::CNT_RESET;
      end
    end
    if (wd_wr && !s_q.armed)
    begin
      s_d.armed = 1'b1;
      s_d.cnt = iow_pkg::CNT_RESET;
    end
    if (wd_rd)
    begin
      s_d.cnt = iow_pkg::CNT_RESET;
      s_d.irq = 1'b0;
    end
    // fixed pulse length
    // A stretched pulse lets a slow reset input on the far side still see it.
    if (s_q.rst_left != '0)
    begin
      s_d.rst_left = s_q.rst_left - 1'b1;
    end
    if (expire)
    begin
      s_d.armed = 1'b0;
      s_d.cnt = iow_pkg::CNT_RESET;
      if (irq_sel)
      begin
        s_d.irq = 1'b1;
      end
      else
      begin
        s_d.rst_left = iow_pkg::RST_LEN;
      end
    end
    s_d.cpu_reset = s_d.rst_left != '0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '{unlock: iow_pkg::UNL_IDLE, enabled: 1'b0, armed: 1'b0,
               cnt: iow_pkg::CNT_RESET, rst_left: '0, cpu_reset: 1'b0, irq: 1'b0,
               mode_sync: 2'h0};
    end
    else if (ce)
    begin
      s_q <= s_d;
    end
  end

  assign cpu_reset = s_q.cpu_reset;
  assign irq = s_q.irq;
  assign enabled = s_q.enabled;
  assign armed = s_q.armed;

  a_arm_on_write: assert property (@(posedge clk) disable iff (srst)
    ce && wd_wr && !s_q.armed && !expire |=> s_q.armed && s_q.cnt == '0)
    else $error("Watchdog not armed by first port write.");

  a_timeout_reset: assert property (@(posedge clk) disable iff (srst)
    ce && expire && !irq_sel |=> cpu_reset [*8])
    else $error("CPU reset not pulsed on expiry.");

  a_refresh_count: assert property (@(posedge clk) disable iff (srst)
    ce && wd_rd |=> s_q.cnt == '0 && !irq)
    else $error("Port read did not restart the timeout.");

  a_count_step: assert property (@(posedge clk) disable iff (srst)
    ce && s_q.armed && s_q.enabled && !wd_rd && !expire && !dat_wr |=>
    s_q.cnt == $past(s_q.cnt) + 1'b1)
    else $error("Timeout counter did not advance.");

  a_enable_seq: assert property (@(posedge clk) disable iff (srst)
    $rose(s_q.enabled) |-> $past(s_q.unlock) == iow_pkg::UNL_SEL && $past(dat_wr)
    && $past(io.data) == iow_pkg::ENABLE_CODE)
    else $error("Watchdog enabled without the exact sequence.");

  a_disable_seq: assert property (@(posedge clk) disable iff (srst)
    ce && dat_wr && s_q.unlock == iow_pkg::UNL_SEL && io.data == iow_pkg::DISABLE_CODE
    |=> !s_q.enabled && !s_q.armed)
    else $error("Disable sequence did not stop the watchdog.");

  a_expire_irq: assert property (@(posedge clk) disable iff (srst)
    ce && expire && irq_sel |=> irq && !cpu_reset && !s_q.armed)
    else $error("Interrupt not raised on expiry.");

  a_reset_clear: assert property (@(posedge clk)
    srst |=> !s_q.enabled && !s_q.armed && s_q.cnt == '0 && !cpu_reset && !irq)
    else $error("Reset left watchdog state behind.");

  // The checks below read registered state and io decodes; the registered state each samples is what the last edge left.
  a_irq_holds: assert property (@(posedge clk) disable iff (srst)
    irq && !(ce && wd_rd) |=> irq)
    else $error("Interrupt dropped without a port read.");

  a_enable_holds: assert property (@(posedge clk) disable iff (srst)
    s_q.enabled && !(ce && dat_wr) |=> s_q.enabled)
    else $error("Watchdog left the enabled state on its own.");

  a_unlock_end: assert property (@(posedge clk) disable iff (srst)
    ce && dat_wr |=> s_q.unlock == iow_pkg::UNL_IDLE)
    else $error("Unlock state survived a data port write.");

  a_wrong_index: assert property (@(posedge clk) disable iff (srst)
    ce && idx_wr && io.data != iow_pkg::UNLOCK_CODE && io.data != iow_pkg::SELECT_CODE |=>
    s_q.unlock == iow_pkg::UNL_IDLE)
    else $error("Wrong index value did not end the unlock sequence.");

  a_idle_count: assert property (@(posedge clk) disable iff (srst)
    !s_q.armed |-> s_q.cnt == '0)
    else $error("Counter not clear while unarmed.");

  a_disabled_count: assert property (@(posedge clk) disable iff (srst)
    !s_q.enabled |-> s_q.cnt == '0)
    else $error("Counter not clear while disabled.");

  a_pulse_cause: assert property (@(posedge clk) disable iff (srst)
    $rose(cpu_reset) |-> $past(expire) && !$past(irq_sel))
    else $error("CPU reset rose without a reset mode expiry.");

  a_irq_cause: assert property (@(posedge clk) disable iff (srst)
    $rose(irq) |-> $past(expire) && $past(irq_sel))
    else $error("Interrupt rose without an interrupt mode expiry.");

  a_arm_cause: assert property (@(posedge clk) disable iff (srst)
    $rose(s_q.armed) |-> $past(wd_wr) && $past(ce))
    else $error("Watchdog armed without a port write.");

  a_write_ignored: assert property (@(posedge clk) disable iff (srst)
    ce && wd_wr && s_q.armed && !expire |=> s_q.armed)
    else $error("Port write while armed changed the arm state.");

  a_ce_freeze: assert property (@(posedge clk) disable iff (srst)
    !ce |=> $stable(s_q))
    else $error("State moved while the clock enable was low.");

  a_expire_disarms: assert property (@(posedge clk) disable iff (srst)
    ce && expire |=> !s_q.armed && s_q.cnt == '0)
    else $error("Expiry did not disarm the watchdog.");

  a_read_keeps_arm: assert property (@(posedge clk) disable iff (srst)
    ce && wd_rd && s_q.armed |=> s_q.armed)
    else $error("Refresh read disarmed the watchdog.");

  c_enable: cover property (@(posedge clk) disable iff (srst) $rose(s_q.enabled));
  c_reset_fire: cover property (@(posedge clk) disable iff (srst) $rose(cpu_reset));
  c_irq_fire: cover property (@(posedge clk) disable iff (srst) $rose(irq));
  c_refresh: cover property (@(posedge clk) disable iff (srst) ce && wd_rd && s_q.enabled);
  c_disable: cover property (@(posedge clk) disable iff (srst) $fell(s_q.enabled));

endmodule : iow_watchdog

// ==== dv/iow_host.sv ====
`timescale 1ns/1ps
module iow_host (
  input wire logic clk,
  output iow_pkg::iow_io_t io
);
  initial io = '0;
  // one strobe per cycle.
  // Released address and data lines show the inverse and both strobes drop low, so stale values are never mistaken for a request.
  task automatic op(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io = {w, ~w, a, d};
    @(posedge clk);
    #1;
    io = {2'b00, ~a, ~d};
  endtask : op
endmodule : iow_host

// ==== dv/iow_watchdog_tb.sv ====
`timescale 1ns/1ps
module iow_watchdog_tb;
  logic clk, srst, ce, irq_mode, cpu_reset, irq, enabled, armed;
  iow_pkg::iow_io_t io;
  int failures = 0;
  int cmp_count = 0;
  localparam int TO_CYC = 100;
  iow_watchdog #(.TIMEOUT_CYC(TO_CYC)) iow_watchdog_i (.clk(clk), .srst(srst), .ce(ce),
    .io(io), .irq_mode(irq_mode), .cpu_reset(cpu_reset), .irq(irq), .enabled(enabled),
    .armed(armed));
  iow_host iow_host_i (.clk(clk), .io(io));
  task automatic check(input logic seen, input logic exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %0t saw %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    $display("failures %0d compares %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc
  task automatic unlock(input logic [7:0] code);
    iow_host_i.op(1, 16'h03F0, 8'h87);
    iow_host_i.op(1, 16'h03F0, 8'h87);
    iow_host_i.op(1, 16'h03F0, 8'h14);
    iow_host_i.op(1, 16'h03F1, code);
  endtask : unlock
  task automatic test_enable();
    iow_host_i.op(1, 16'h0443, 8'h00);
    check(armed, 1'b1);
    unlock(8'h55);
    check(enabled, 1'b0);
    unlock(8'h9C);
    check(enabled, 1'b1);
  endtask : test_enable
  task automatic test_expire();
    wait_cyc(90);
    iow_host_i.op(0, 16'h0443, 8'h00);
    // Expiry is exactly one timeout after the edge that took the read.
    wait_cyc(TO_CYC - 1);
    check(cpu_reset, 1'b0);
    wait_cyc(1);
    check(cpu_reset, 1'b1);
    check(armed, 1'b0);
    check(irq, 1'b0);
    wait_cyc(7);
    check(cpu_reset, 1'b1);
    wait_cyc(1);
    check(cpu_reset, 1'b0);
  endtask : test_expire
  task automatic test_irq();
    wait_cyc(10);
    irq_mode = 1'b1;
    iow_host_i.op(1, 16'h0443, 8'h00);
    wait_cyc(50);
    // Twenty frozen cycles push the expiry out by twenty.
    ce = 1'b0;
    wait_cyc(20);
    check(armed, 1'b1);
    ce = 1'b1;
    wait_cyc(TO_CYC - 51);
    check(irq, 1'b0);
    wait_cyc(1);
    check(irq, 1'b1);
    check(cpu_reset, 1'b0);
    wait_cyc(3);
    check(irq, 1'b1);
    iow_host_i.op(0, 16'h0443, 8'h00);
    check(irq, 1'b0);
  endtask : test_irq
  task automatic test_reset();
    iow_host_i.op(1, 16'h0443, 8'h00);
    check(armed, 1'b1);
    unlock(8'h8C);
    check(enabled, 1'b0);
    check(armed, 1'b0);
    iow_host_i.op(1, 16'h0443, 8'h00);
    wait_cyc(TO_CYC + 10);
    check(armed, 1'b1);
    check(irq | cpu_reset, 1'b0);
    unlock(8'h9C);
    check(enabled, 1'b1);
    srst = 1'b1;
    wait_cyc(1);
    srst = 1'b0;
    check(cpu_reset | irq | enabled | armed, 1'b0);
  endtask : test_reset
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    #200000;
    failures++;
    finish_test();
  end
  initial
  begin
    srst = 1'b1;
    ce = 1'b1;
    irq_mode = 1'b0;
    wait_cyc(2);
    srst = 1'b0;
    check(cpu_reset | irq | enabled | armed, 1'b0);
    test_enable();
    test_expire();
    test_irq();
    test_reset();
    finish_test();
  end
endmodule : iow_watchdog_tb
